// *** design/cbf_fault_irq.sv ***
// Boost fault flags, three interrupt mask registers, interrupt pin and enable-field clear.
// Assumes the host register block forwards accesses on this clock and owns the enable field.
//
// Operation
// - Bus overvoltage during boost sets boost flag bit 7.
// - Boost overload sets boost flag bit 6.
// - Battery too low for boost sets boost flag bit 5.
// - Battery overvoltage during boost sets boost flag bit 4.
// - Expiry of the 32 s boost timer sets boost flag bit 3.
// - A boost fault whose flag is not already set forces the charge/boost enable field to 00.
// - Mask bits: 0 passes, 1 masks; all read/write, reset to 0.
// - System mask bit 7 masks the thermal shutdown interrupt.
// - System mask bit 6 masks the bus overvoltage interrupt.
// - System mask bit 0 masks the LED driver fault; bits 5 to 1 unused.
// - Masking never stops the protective action of a fault.
// - A masked fault never asserts the interrupt pin.
// - Charger mask bits 7, 6, 5: reverse, bad adaptor, battery overvoltage.
// - Charger mask bit 4 masks charge done, bit 3 recharge request.
// - Charger mask bit 2 masks the 32 minute charge timeout.
// - Charger mask bit 1 masks thermal regulation, bit 0 input limit.
// - Boost mask bit 7 masks bus overvoltage, bit 6 overload.
// - Boost mask bit 5 masks low battery, bit 4 battery overvoltage.
// - Boost mask bit 3 masks the boost timeout; bits 2 to 0 unused.
// - Charger faults clear the enable field; recharge only when it holds 10.
// - Charger flags share the bit order of their mask register.
`timescale 1ns/100ps
`default_nettype none
module cbf_fault_irq
  import cbf_pkg::*;
#(
  parameter longint BOOST_TIMEOUT_CYCLES = CBF_BOOST_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire cbf_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [CBF_BOOST_DET_W-1:0] boost_det_pin,
  input wire logic boost_run_pin,
  input wire logic [7:0] system_flags,
  input wire logic [7:0] charger_flags,
  input wire logic [1:0] charge_enable_field,
  output logic charge_enable_clear,
  output logic [7:0] boost_fault_flags_out,
  output logic irq_n
);

  if (BOOST_TIMEOUT_CYCLES < 1) begin : g_bad_timeout
    $error("cbf_fault_irq: BOOST_TIMEOUT_CYCLES must be positive");
  end

  // Analog detectors are asynchronous to clk
  logic [CBF_BOOST_DET_W-1:0] det_sync;
  logic [0:0] run_sync;
  cbf_boost_det_t det;
  logic timer_expired;

  cbf_sync #(
    .WIDTH(CBF_BOOST_DET_W)
  ) u_det_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(boost_det_pin),
    .sync_out(det_sync)
  );

  cbf_sync #(
    .WIDTH(1)
  ) u_run_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(boost_run_pin),
    .sync_out(run_sync)
  );

  assign det = cbf_boost_det_t'(det_sync);

  // Timer stops once boost is off; the enable clear drops boost_run_pin outside this block
  cbf_boost_timer #(
    .TIMEOUT_CYCLES(BOOST_TIMEOUT_CYCLES)
  ) u_timer (
    .clk(clk),
    .rstn(rstn),
    .run(run_sync[0]),
    .expired(timer_expired)
  );

  // Register state
  logic [7:0] boost_flags;
  logic [7:0] sys_mask;
  logic [7:0] chg_mask;
  logic [7:0] boost_mask;
  logic [7:0] chg_prev;
  logic [7:0] next_boost_flags;
  logic [7:0] next_sys_mask;
  logic [7:0] next_chg_mask;
  logic [7:0] next_boost_mask;
  logic [7:0] next_chg_prev;
  logic [7:0] next_reg_rdata;
  logic next_charge_enable_clear;
  logic next_irq_n;

  // Events and decode
  logic [7:0] boost_set;
  logic boost_clr;
  logic [7:0] chg_rise;
  logic [7:0] sys_pending;
  logic [7:0] chg_pending;
  logic [7:0] boost_pending;
  logic boost_new_fault;
  logic chg_new_fault;
  logic recharge_stop;

  always_comb begin
    boost_set = 8'h00;
    boost_set[CBF_BST_BUS_OV_BIT] = det.bus_overvolt;
    boost_set[CBF_BST_OVERLOAD_BIT] = det.overload;
    boost_set[CBF_BST_LOW_BATT_BIT] = det.low_batt;
    boost_set[CBF_BST_BATT_OV_BIT] = det.batt_overvolt;
    boost_set[CBF_BST_TIMEOUT_BIT] = timer_expired;
    // Reading the flag register clears it; a fault present in that cycle stays set
    boost_clr = reg_req.rd && (reg_req.addr == CBF_BOOST_FLAGS_ADDR);
    next_boost_flags = ((boost_clr ? CBF_FLAGS_RESET : boost_flags) | boost_set) & CBF_BOOST_USED;
  end

  // Mask registers keep every written bit, unused ones included
  always_comb begin
    next_sys_mask = sys_mask;
    next_chg_mask = chg_mask;
    next_boost_mask = boost_mask;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        CBF_SYS_MASK_ADDR: begin
          next_sys_mask = reg_req.wdata;
        end
        CBF_CHG_MASK_ADDR: begin
          next_chg_mask = reg_req.wdata;
        end
        CBF_BOOST_MASK_ADDR: begin
          next_boost_mask = reg_req.wdata;
        end
        default: begin
          next_sys_mask = sys_mask;
        end
      endcase
    end
  end

  // Read data is registered; the flag register shows its value before the clear
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        CBF_BOOST_FLAGS_ADDR: begin
          next_reg_rdata = boost_flags;
        end
        CBF_SYS_MASK_ADDR: begin
          next_reg_rdata = sys_mask;
        end
        CBF_CHG_MASK_ADDR: begin
          next_reg_rdata = chg_mask;
        end
        CBF_BOOST_MASK_ADDR: begin
          next_reg_rdata = boost_mask;
        end
        default: begin
          next_reg_rdata = CBF_UNMAPPED_READ;
        end
      endcase
    end
  end

  // Protective action uses raw events, never the masks
  always_comb begin
    next_chg_prev = charger_flags;
    chg_rise = charger_flags & ~chg_prev;
    boost_new_fault = |(boost_set & ~boost_flags);
    chg_new_fault = |(chg_rise & CBF_CHG_FAULTS);
    recharge_stop = chg_rise[CBF_CHG_RECHARGE_BIT]
      && (charge_enable_field == CBF_ENABLE_RECHARGE_STOPS);
    next_charge_enable_clear = (boost_new_fault || chg_new_fault || recharge_stop)
      && (charge_enable_field != CBF_ENABLE_OFF);
  end

  // Per-source pending terms; mask bit set removes the source
  always_comb begin
    sys_pending = 8'h00;
    sys_pending[CBF_SYS_THERMAL_BIT] = system_flags[CBF_SYS_THERMAL_BIT]
      && !sys_mask[CBF_SYS_THERMAL_BIT];
    sys_pending[CBF_SYS_BUS_OV_BIT] = system_flags[CBF_SYS_BUS_OV_BIT]
      && !sys_mask[CBF_SYS_BUS_OV_BIT];
    sys_pending[CBF_SYS_LED_BIT] = system_flags[CBF_SYS_LED_BIT]
      && !sys_mask[CBF_SYS_LED_BIT];
    // Charger flags line up bit for bit with their masks
    chg_pending = charger_flags & ~chg_mask & CBF_CHG_USED;
    boost_pending = boost_flags & ~boost_mask & CBF_BOOST_USED;
    next_irq_n = !(|sys_pending || |chg_pending || |boost_pending);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boost_flags <= CBF_FLAGS_RESET;
      sys_mask <= CBF_MASK_RESET;
      chg_mask <= CBF_MASK_RESET;
      boost_mask <= CBF_MASK_RESET;
      chg_prev <= CBF_FLAGS_RESET;
      reg_rdata <= CBF_UNMAPPED_READ;
      charge_enable_clear <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      boost_flags <= next_boost_flags;
      sys_mask <= next_sys_mask;
      chg_mask <= next_chg_mask;
      boost_mask <= next_boost_mask;
      chg_prev <= next_chg_prev;
      reg_rdata <= next_reg_rdata;
      charge_enable_clear <= next_charge_enable_clear;
      irq_n <= next_irq_n;
    end
  end

  assign boost_fault_flags_out = boost_flags;

endmodule : cbf_fault_irq
`default_nettype wire

// *** design/cbf_pkg.sv ***
// Constants, field layouts and carriers for the charger boost fault and mask block.
// Assumes a register block on the same clock that forwards host register accesses.
package cbf_pkg;

  // Register offsets as seen by the host
  localparam logic [7:0] CBF_BOOST_FLAGS_ADDR = 8'h0A;
  localparam logic [7:0] CBF_SYS_MASK_ADDR = 8'h0B;
  localparam logic [7:0] CBF_CHG_MASK_ADDR = 8'h0C;
  localparam logic [7:0] CBF_BOOST_MASK_ADDR = 8'h0D;

  // Reset values
  localparam logic [7:0] CBF_FLAGS_RESET = 8'h00;
  localparam logic [7:0] CBF_MASK_RESET = 8'h00;
  localparam logic [7:0] CBF_UNMAPPED_READ = 8'h00;

  // Boost fault flag and mask bit positions
  localparam int CBF_BST_BUS_OV_BIT = 7;
  localparam int CBF_BST_OVERLOAD_BIT = 6;
  localparam int CBF_BST_LOW_BATT_BIT = 5;
  localparam int CBF_BST_BATT_OV_BIT = 4;
  localparam int CBF_BST_TIMEOUT_BIT = 3;

  // System fault mask bit positions
  localparam int CBF_SYS_THERMAL_BIT = 7;
  localparam int CBF_SYS_BUS_OV_BIT = 6;
  localparam int CBF_SYS_LED_BIT = 0;

  // Charger flag and mask bit positions
  localparam int CBF_CHG_REVERSE_BIT = 7;
  localparam int CBF_CHG_BAD_ADAPTOR_BIT = 6;
  localparam int CBF_CHG_BATT_OV_BIT = 5;
  localparam int CBF_CHG_DONE_BIT = 4;
  localparam int CBF_CHG_RECHARGE_BIT = 3;
  localparam int CBF_CHG_TIMEOUT_BIT = 2;
  localparam int CBF_CHG_THERM_REG_BIT = 1;
  localparam int CBF_CHG_DPM_BIT = 0;

  // Bits of each flag register that carry a live source
  localparam logic [7:0] CBF_SYS_USED = 8'hC1;
  localparam logic [7:0] CBF_CHG_USED = 8'hFF;
  localparam logic [7:0] CBF_BOOST_USED = 8'hF8;
  // Charger bits that are faults and so stop the charger
  localparam logic [7:0] CBF_CHG_FAULTS = 8'hE4;

  // Charge/boost enable field values
  localparam logic [1:0] CBF_ENABLE_OFF = 2'h0;
  localparam logic [1:0] CBF_ENABLE_RECHARGE_STOPS = 2'h2;

  // Boost safety timer
  localparam longint CBF_CLK_HZ = 64'd20000000;
  localparam longint CBF_BOOST_TIMEOUT_S = 64'd32;
  localparam longint CBF_BOOST_TIMEOUT_CYCLES = CBF_BOOST_TIMEOUT_S * CBF_CLK_HZ;

  // Number of analog boost detectors arriving on pins
  localparam int CBF_BOOST_DET_W = 4;

  // Synchronised analog boost detector levels
  typedef struct packed {
    logic bus_overvolt;
    logic overload;
    logic low_batt;
    logic batt_overvolt;
  } cbf_boost_det_t;

  // Register access from the host register block
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cbf_reg_req_t;

endpackage : cbf_pkg

// *** design/cbf_sync.sv ***
// Two-flop synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous levels; pulses shorter than one clock may be missed.
`timescale 1ns/100ps
`default_nettype none
module cbf_sync
  import cbf_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Refused at elaboration, before any logic is built
  if (WIDTH < 1) begin : g_bad_width
    $error("cbf_sync: WIDTH must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      logic next_meta;
      logic next_out;
      // The first stage feeds only the second stage
      always_comb begin
        next_meta = async_in[i];
        next_out = meta;
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta <= next_meta;
          sync_out[i] <= next_out;
        end
      end
    end
  endgenerate

endmodule : cbf_sync
`default_nettype wire

// *** design/cbf_boost_timer.sv ***
// Boost safety timer: counts while boost runs and pulses once on expiry.
// Assumes run is already synchronised; dropping run restarts the count.
`timescale 1ns/100ps
`default_nettype none
module cbf_boost_timer
  import cbf_pkg::*;
#(
  parameter longint TIMEOUT_CYCLES = CBF_BOOST_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  output logic expired
);

  // The counter is 32 bits wide, so longer spans are refused at elaboration
  if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 64'hFFFFFFFF) begin : g_bad_timeout
    $error("cbf_boost_timer: TIMEOUT_CYCLES out of range");
  end

  localparam logic [31:0] LAST = 32'(TIMEOUT_CYCLES - 1);

  logic [31:0] count;
  logic done;
  logic [31:0] next_count;
  logic next_done;
  logic next_expired;

  // Fires once per run; a held run after expiry does not refire
  always_comb begin
    next_count = count;
    next_done = done;
    next_expired = 1'b0;
    if (!run) begin
      next_count = 32'h0;
      next_done = 1'b0;
    end else if (!done) begin
      if (count == LAST) begin
        next_done = 1'b1;
        next_expired = 1'b1;
      end else begin
        next_count = count + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 32'h0;
      done <= 1'b0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
      expired <= next_expired;
    end
  end

endmodule : cbf_boost_timer
`default_nettype wire

// *** bench/cbf_fault_irq_checker.sv ***
// Checker for the boost fault flags, mask registers and interrupt pin.
// Assumes only the block's ports; mask registers are shadowed from host writes.
`timescale 1ns/100ps
`default_nettype none
module cbf_fault_irq_checker
  import cbf_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire cbf_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [CBF_BOOST_DET_W-1:0] boost_det_pin,
  input wire logic boost_run_pin,
  input wire logic [7:0] system_flags,
  input wire logic [7:0] charger_flags,
  input wire logic [1:0] charge_enable_field,
  input wire logic charge_enable_clear,
  input wire logic [7:0] boost_fault_flags_out,
  input wire logic irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] m [3];
  logic [7:0] next_m [3];
  logic [7:0] msel;
  logic mhit;
  logic cause;
  assign mhit = reg_req.addr inside {[CBF_SYS_MASK_ADDR:CBF_BOOST_MASK_ADDR]};
  assign msel = mhit ? m[2'(reg_req.addr - CBF_SYS_MASK_ADDR)] : 8'h00;
  assign cause = |(system_flags & ~m[0] & CBF_SYS_USED) || |(charger_flags & ~m[1])
    || |(boost_fault_flags_out & ~m[2] & CBF_BOOST_USED);
  always_comb begin
    next_m = m;
    if (reg_req.wr && mhit) begin
      next_m[2'(reg_req.addr - CBF_SYS_MASK_ADDR)] = reg_req.wdata;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m <= '{default: 8'h00};
    end else begin
      m <= next_m;
    end
  end
  // Pin must stay high through both sync stages before the flag can show
  sequence s_held(int i);
    boost_det_pin[i] [*4];
  endsequence
  property p_det(int i);
    s_held(i) |-> boost_fault_flags_out[i + 4];
  endproperty
  chk_bus_ov_flag: assert property (p_det(3)) else $error("bus overvolt flag missing");
  chk_overload_flag: assert property (p_det(2)) else $error("overload flag missing");
  chk_low_batt_flag: assert property (p_det(1)) else $error("low battery flag missing");
  chk_batt_ov_flag: assert property (p_det(0)) else $error("battery overvolt flag missing");
  chk_irq_level: assert property ($past(rstn) |-> irq_n == !$past(cause)) else $error("irq level wrong");
  chk_clear_cause: assert property (charge_enable_clear |-> $past(charge_enable_field) != CBF_ENABLE_OFF)
    else $error("clear without enabled field");
  chk_boost_clear: assert property (|(boost_fault_flags_out & ~$past(boost_fault_flags_out))
    && $past(charge_enable_field) != CBF_ENABLE_OFF |-> charge_enable_clear) else $error("no boost clear");
  chk_chg_clear: assert property (|(charger_flags & ~$past(charger_flags) & CBF_CHG_FAULTS)
    && charge_enable_field != CBF_ENABLE_OFF |=> charge_enable_clear) else $error("no fault clear");
  chk_recharge_clear: assert property ($rose(charger_flags[CBF_CHG_RECHARGE_BIT])
    && charge_enable_field == CBF_ENABLE_RECHARGE_STOPS |=> charge_enable_clear) else $error("no recharge clear");
  chk_mask_readback: assert property (reg_req.rd && mhit |=> reg_rdata == $past(msel))
    else $error("mask readback wrong");
  chk_unused_flags: assert property (boost_fault_flags_out[2:0] == 3'h0) else $error("unused flag set");
endmodule : cbf_fault_irq_checker
bind cbf_fault_irq cbf_fault_irq_checker u_cbf_fault_irq_checker (.clk, .rstn, .reg_req, .reg_rdata,
  .boost_det_pin, .boost_run_pin, .system_flags, .charger_flags, .charge_enable_field,
  .charge_enable_clear, .boost_fault_flags_out, .irq_n);
`default_nettype wire

// *** bench/cbf_host_model.sv ***
// Host model: register reads and writes on the block's request port.
// Assumes one clock; each request lasts one cycle, with an idle cycle after.
`timescale 1ns/100ps
`default_nettype none
module cbf_host_model
  import cbf_pkg::*;
(
  input wire logic clk,
  output var cbf_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  initial reg_req = '0;
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    reg_req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk);
    reg_req <= '0;
    #1;
    q = reg_rdata;
  endtask : access
endmodule : cbf_host_model
`default_nettype wire

// *** bench/cbf_fault_irq_tb_top.sv ***
// Testbench for the boost fault flags, masks and interrupt pin.
// Assumes a 20 MHz clock; the boost timer is cut to 20 cycles to keep runs short.
`timescale 1ns/100ps
`default_nettype none
module cbf_fault_irq_tb_top
  import cbf_pkg::*;
;
  localparam int TMO = 20;
  logic clk, rstn, run, irq_n, clr;
  logic [3:0] det;
  logic [7:0] sf, cf, rdata, bff, q, bfe;
  logic [1:0] fld;
  logic [7:0] m [3];
  cbf_reg_req_t req;
  int err_total, checks_done, ncl, c0;
  // Last entry: done, thermal regulation and input limit are not faults and must not stop the charger
  logic [7:0] cfl [8] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h08, 8'h08, 8'h80, 8'h13};
  logic [1:0] cfd [8] = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1};
  int cex [8] = '{1, 1, 1, 1, 0, 1, 0, 0};
  cbf_fault_irq #(.BOOST_TIMEOUT_CYCLES(TMO)) u_cbf_fault_irq (.clk, .rstn, .reg_req(req), .reg_rdata(rdata),
    .boost_det_pin(det), .boost_run_pin(run), .system_flags(sf), .charger_flags(cf),
    .charge_enable_field(fld), .charge_enable_clear(clr), .boost_fault_flags_out(bff), .irq_n);
  cbf_host_model u_cbf_host_model (.clk, .reg_req(req), .reg_rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // An unknown clear counts heavily so that it can never pass as no pulse
  always @(posedge clk) if (clr !== 1'b0) ncl += (clr === 1'b1) ? 1 : 100;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic cmp_rdata(input logic [7:0] e, input logic [7:0] g);
    cmp("rdata", e, g);
  endtask : cmp_rdata
  task automatic cmp_irq(input logic e);
    cmp("irq_n", 8'(e), 8'(irq_n));
  endtask : cmp_irq
  task automatic cmp_flags(input logic [7:0] e);
    cmp("boost_flags", e, bff);
  endtask : cmp_flags
  task automatic cmp_clear(input int e, input int c);
    cmp("clear_count", 8'(e), 8'(c));
  endtask : cmp_clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cbf_host_model.access(1'b1, a, d, q);
    if (a inside {[8'h0B:8'h0D]}) m[a - 8'h0B] = d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_cbf_host_model.access(1'b0, a, 8'h00, q);
    cmp_rdata(e, q);
  endtask : rd
  task automatic put(input logic [7:0] s, input logic [7:0] c, input logic [1:0] f, input logic [3:0] d, input logic r);
    @(posedge clk);
    sf <= s;
    cf <= c;
    fld <= f;
    det <= d;
    run <= r;
  endtask : put
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Expected pin level from the model's own masks and flags
  function automatic logic exp_irq();
    return !(|(sf & ~m[0] & CBF_SYS_USED) || |(cf & ~m[1]) || |(bfe & ~m[2] & CBF_BOOST_USED));
  endfunction : exp_irq
  task automatic stop_test();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    stop_test();
  end
  initial begin
    void'($urandom(45446));
    {rstn, sf, cf, fld, det, run, bfe} = '0;
    m = '{default: 8'h00};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 10; a < 15; a++) rd(8'(a), 8'h00);
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'h00);
    for (int i = 0; i < 3; i++) wr(8'h0B + 8'(i), 8'($urandom));
    for (int i = 0; i < 3; i++) rd(8'h0B + 8'(i), m[i]);
    wr(8'h0B, 8'h00);
    wr(8'h0C, 8'h00);
    for (int k = 0; k < 32; k++) begin
      wr(k < 16 ? 8'h0B : 8'h0C, k[0] ? 8'(1 << (k / 2 % 8)) : 8'h00);
      put(k < 16 ? 8'(1 << (k / 2)) : 8'h00, k < 16 ? 8'h00 : 8'(1 << (k / 2 - 8)), 2'h0, 4'h0, 1'b0);
      tick(3);
      cmp_irq(exp_irq());
    end
    // Charger masked on purpose: protection must still stop the charger
    wr(8'h0C, 8'hFF);
    for (int j = 0; j < 8; j++) begin
      put(8'h00, 8'h00, cfd[j], 4'h0, 1'b0);
      tick(2);
      c0 = ncl;
      put(8'h00, cfl[j], cfd[j], 4'h0, 1'b0);
      tick(3);
      cmp_clear(cex[j], ncl - c0);
    end
    put(8'h00, 8'h00, 2'h1, 4'h0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h0D, i[0] ? 8'(1 << (i + 3)) : 8'h00);
      c0 = ncl;
      put(8'h00, 8'h00, 2'h1, i > 0 ? 4'(1 << (i - 1)) : 4'h0, i == 0);
      tick(TMO);
      // The timer must not expire before it has run its full span
      if (i == 0) cmp_flags(8'h00);
      tick(10);
      bfe = 8'(1 << (i + 3));
      cmp_flags(bfe);
      cmp_clear(1, ncl - c0);
      cmp_irq(exp_irq());
      put(8'h00, 8'h00, 2'h1, 4'h0, 1'b0);
      tick(3);
      rd(8'h0A, bfe);
      bfe = 8'h00;
      rd(8'h0A, 8'h00);
    end
    // Leave a flag set so that the mid-run reset has something to clear
    bfe = 8'h80;
    put(8'h00, 8'h00, 2'h1, 4'h8, 1'b0);
    tick(5);
    cmp_flags(bfe);
    put(8'h00, 8'h00, 2'h0, 4'h0, 1'b0);
    tick(3);
    @(posedge clk);
    rstn <= 1'b0;
    tick(3);
    @(posedge clk);
    rstn <= 1'b1;
    m = '{default: 8'h00};
    bfe = 8'h00;
    for (int i = 0; i < 3; i++) rd(8'h0B + 8'(i), 8'h00);
    cmp_flags(bfe);
    cmp_irq(exp_irq());
    stop_test();
  end
endmodule : cbf_fault_irq_tb_top
`default_nettype wire
